// *** tmu_pkg.sv ***
// Purpose: constants and carriers for the temporary unprotect option logic
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes: offsets of the option registers are chosen locally
package tmu_pkg;
    localparam logic [7:0] OFS_KEY4 = 8'h00;
    localparam logic [7:0] OFS_KEY5 = 8'h04;
    localparam logic [7:0] OFS_KEY6 = 8'h08;
    localparam logic [7:0] OFS_KEY7 = 8'h0c;
    localparam logic [7:0] OFS_FAIL = 8'h10;
    localparam logic [7:0] OFS_BOOT = 8'h14;
    localparam logic [7:0] OFS_BOOT_N = 8'h18;
    localparam logic [7:0] OFS_CFG = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [3:0] FEATURE_DISABLED = 4'h5;
    localparam logic [7:0] FAIL_LIMIT = 8'h08;
    localparam logic [7:0] BOOT_ON = 8'h55;
    localparam logic [7:0] BOOT_ON_N = 8'haa;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h05;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef struct packed {
        logic [7:0] b7;
        logic [7:0] b6;
        logic [7:0] b5;
        logic [7:0] b4;
    } key_s;
endpackage

// *** temp_unprotect_option_logic.sv ***
// Purpose: stored unlock keys, failure counter, erase trigger and boot select
// Assumes: attempts arrive as one-cycle pulses on the core clock
// Notes: erase request holds until erase_done_i clears it with the count below the limit or the feature disabled
`timescale 1ns/100ps
module temp_unprotect_option_logic (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // unlock attempt from programming tool
    input wire logic attempt_i,
    input wire tmu_pkg::key_s attempt_key_i,
    // status toward flash and boot logic
    input wire logic code_empty_i,
    input wire logic erase_done_i,
    output logic unlock_ok_o,
    output logic erase_req_o,
    output logic boot_loader_o
);
    tmu_pkg::key_s key_reg;
    logic [7:0] fail_reg;
    logic [7:0] boot_reg;
    logic [7:0] boot_n_reg;
    logic [3:0] cfg_reg;
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_next;
    logic feature_on;
    logic bad_try;
    logic fail_wr;

    assign feature_on = (cfg_reg != tmu_pkg::FEATURE_DISABLED);
    assign bad_try = attempt_i && feature_on && (attempt_key_i != key_reg);
    assign fail_wr = wr_pend_reg && (addr_reg == tmu_pkg::OFS_FAIL)
                     && !feature_on;

    // address phase capture; zero wait state from the first clock edge after reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (hready_i) begin
            wr_pend_reg <= hsel_i && hwrite_i && (htrans_i == tmu_pkg::HTRANS_NONSEQ);
            addr_reg <= haddr_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // software writes of key bytes, boot bytes and feature code
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_reg <= {4{tmu_pkg::KEY_RESET}};
            boot_reg <= 8'h00;
            boot_n_reg <= 8'h00;
            cfg_reg <= tmu_pkg::CFG_RESET[3:0];
        end else if (wr_pend_reg) begin
            unique case (addr_reg)
                tmu_pkg::OFS_KEY4: key_reg.b4 <= hwdata_i[7:0];
                tmu_pkg::OFS_KEY5: key_reg.b5 <= hwdata_i[7:0];
                tmu_pkg::OFS_KEY6: key_reg.b6 <= hwdata_i[7:0];
                tmu_pkg::OFS_KEY7: key_reg.b7 <= hwdata_i[7:0];
                tmu_pkg::OFS_BOOT: boot_reg <= hwdata_i[7:0];
                tmu_pkg::OFS_BOOT_N: boot_n_reg <= hwdata_i[7:0];
                tmu_pkg::OFS_CFG: cfg_reg <= hwdata_i[3:0];
                default: cfg_reg <= cfg_reg;
            endcase
        end
    end

    // failure counter; counting saturates at the limit
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fail_reg <= 8'h00;
        end else if (fail_wr) begin
            fail_reg <= hwdata_i[7:0];
        end else if (bad_try && fail_reg < tmu_pkg::FAIL_LIMIT) begin
            fail_reg <= fail_reg + 8'h01;
        end
    end

    // erase request; set wins over the done clear
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            erase_req_o <= 1'b0;
        end else if (fail_reg >= tmu_pkg::FAIL_LIMIT && feature_on) begin
            erase_req_o <= 1'b1;
        end else if (erase_done_i) begin
            erase_req_o <= 1'b0;
        end
    end

    // unlock result and boot choice
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_ok_o <= 1'b0;
            boot_loader_o <= 1'b0;
        end else begin
            if (attempt_i) begin
                unlock_ok_o <= feature_on && !bad_try && fail_reg < tmu_pkg::FAIL_LIMIT;
            end
            boot_loader_o <= code_empty_i || ((boot_reg == tmu_pkg::BOOT_ON)
                             && (boot_n_reg == tmu_pkg::BOOT_ON_N));
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (haddr_i)
            tmu_pkg::OFS_KEY4: rdata_next[7:0] = key_reg.b4;
            tmu_pkg::OFS_KEY5: rdata_next[7:0] = key_reg.b5;
            tmu_pkg::OFS_KEY6: rdata_next[7:0] = key_reg.b6;
            tmu_pkg::OFS_KEY7: rdata_next[7:0] = key_reg.b7;
            tmu_pkg::OFS_FAIL: rdata_next[7:0] = fail_reg;
            tmu_pkg::OFS_BOOT: rdata_next[7:0] = boot_reg;
            tmu_pkg::OFS_BOOT_N: rdata_next[7:0] = boot_n_reg;
            tmu_pkg::OFS_CFG: rdata_next[3:0] = cfg_reg;
            tmu_pkg::OFS_STAT: rdata_next[2:0] = {boot_loader_o, erase_req_o, unlock_ok_o};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data registered from the address phase
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i && hsel_i && !hwrite_i
                     && (htrans_i == tmu_pkg::HTRANS_NONSEQ)) begin
            hrdata_o <= rdata_next;
        end
    end
endmodule

// *** tmu_sva.sv ***
// Purpose: port checks of the unprotect option logic
// Assumes: hready_i fed from hreadyout_o
// Notes: counter is internal, bench reads it
`timescale 1ns/100ps
module tmu_sva (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic attempt_i,
    input wire logic code_empty_i,
    input wire logic erase_done_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic unlock_ok_o,
    input wire logic erase_req_o,
    input wire logic boot_loader_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    zero_wait_a: assert property ($past(resetn_i) |-> hreadyout_o && !hresp_o)
        else $error("bus stalled");
    boot_empty_a: assert property (code_empty_i |=> boot_loader_o)
        else $error("boot not forced");
    erase_hold_a: assert property (erase_req_o && !erase_done_i |=> erase_req_o)
        else $error("erase dropped");
    ok_cause_a: assert property ($changed(unlock_ok_o) |-> $past(attempt_i))
        else $error("result without attempt");
    ok_hold_a: assert property (!attempt_i |=> $stable(unlock_ok_o))
        else $error("result moved between attempts");
endmodule
bind temp_unprotect_option_logic tmu_sva sva (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .attempt_i(attempt_i), .code_empty_i(code_empty_i), .erase_done_i(erase_done_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .unlock_ok_o(unlock_ok_o),
    .erase_req_o(erase_req_o), .boot_loader_o(boot_loader_o));

// *** tmu_tool.sv ***
// Purpose: programming tool offering unlock keys
// Assumes: one-cycle attempt pulse
// Notes: key lines show the inverse once released
`timescale 1ns/100ps
module tmu_tool (
    // clock
    input wire logic clk_i,
    // attempt
    output logic attempt_o,
    output tmu_pkg::key_s key_o
);
    initial begin
        attempt_o = 1'b0;
        key_o = 32'h0;
    end
    task automatic offer(input tmu_pkg::key_s k);
        @(posedge clk_i);
        attempt_o <= 1'b1;
        key_o <= k;
        @(posedge clk_i);
        attempt_o <= 1'b0;
        key_o <= ~k;
    endtask
endmodule

// *** tb_temp_unprotect_option_logic.sv ***
// Purpose: self-checking bench of the unprotect option logic
// Assumes: zero-wait slave
// Notes: stored keys avoid 0x00 and 0xff
`timescale 1ns/100ps
module tb_temp_unprotect_option_logic;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, empty = 1'b0;
    logic done = 1'b0, rdy, hresp, att, ok, er, bl;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    tmu_pkg::key_s key;
    int bad_count = 0, samples_checked = 0;
    temp_unprotect_option_logic uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy),
        .hresp_o(hresp), .attempt_i(att), .attempt_key_i(key), .code_empty_i(empty),
        .erase_done_i(done), .unlock_ok_o(ok), .erase_req_o(er), .boot_loader_o(bl));
    tmu_tool tool (.clk_i(core_clk_i), .attempt_o(att), .key_o(key));
    initial forever #10 core_clk_i = ~core_clk_i;
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic edge_rdy();
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk_i);
            if (rdy === 1'b1) return;
        end
        bad_count++;
        report_and_stop();
    endtask
    // hready is never assumed: each phase waits for it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        hsel <= 1'b1;
        htrans <= tmu_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
    endtask
    task automatic settle();
        repeat (3) @(negedge core_clk_i);
    endtask
    task automatic pulse_done();
        @(posedge core_clk_i);
        done <= 1'b1;
        @(posedge core_clk_i);
        done <= 1'b0;
        settle();
    endtask
    task automatic t_regs();
        bus(0, tmu_pkg::OFS_CFG, 0);
        check(rd, 32'h5);
        bus(0, 8'h24, 0);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) bus(1, 8'(i * 4), 32'(8'h11 * (i + 1)));
        bus(1, tmu_pkg::OFS_FAIL, 32'h5);
        bus(1, tmu_pkg::OFS_CFG, 32'ha);
        bus(1, tmu_pkg::OFS_FAIL, 32'h0);
        bus(0, tmu_pkg::OFS_FAIL, 0);
        check(rd, 32'h5);
    endtask
    task automatic t_attempts();
        tool.offer(32'h44332211);
        settle();
        check(ok, 1'b1);
        for (int i = 6; i < 10; i++) begin
            tool.offer(32'h44332212);
            bus(0, tmu_pkg::OFS_FAIL, 0);
            check(rd, (i > 8) ? 32'h8 : 32'(i));
            settle();
            check({ok, er}, {1'b0, i > 7});
        end
        pulse_done();
        check(er, 1'b1);
        bus(1, tmu_pkg::OFS_CFG, 32'h5);
        pulse_done();
        check(er, 1'b0);
    endtask
    task automatic t_boot();
        bus(1, tmu_pkg::OFS_BOOT, 32'h55);
        bus(1, tmu_pkg::OFS_BOOT_N, 32'haa);
        settle();
        check(bl, 1'b1);
        bus(1, tmu_pkg::OFS_BOOT_N, 32'hab);
        settle();
        check(bl, 1'b0);
        @(posedge core_clk_i);
        empty <= 1'b1;
        settle();
        check(bl, 1'b1);
        bus(0, tmu_pkg::OFS_STAT, 0);
        check(rd, 32'h4);
    endtask
    initial begin
        repeat (20) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_attempts();
        t_boot();
        report_and_stop();
    end
endmodule
